// ---- hdl/ublr_pkg.sv ----
package ublr_pkg;

  // ************************************************************
  // register offsets
  // ************************************************************
  localparam logic [7:0] MODE_OFF = 8'h04;
  localparam logic [7:0] TX_HOLD_OFF = 8'h1c;
  localparam logic [7:0] STATUS_OFF = 8'h14;
  localparam logic [7:0] BAUD_DIV_OFF = 8'h20;
  localparam logic [7:0] RX_TIMEOUT_OFF = 8'h24;
  localparam logic [7:0] TX_GUARD_OFF = 8'h28;
  localparam logic [7:0] LIN_MODE_OFF = 8'h54;
  localparam logic [7:0] LIN_ID_OFF = 8'h58;
  localparam logic [7:0] WP_MODE_OFF = 8'he4;
  localparam logic [7:0] WP_STATUS_OFF = 8'he8;

  // ************************************************************
  // fields and reset values
  // ************************************************************
  localparam logic [23:0] PROTECT_KEY_VAL = 24'h555341;
  localparam int PROTECT_KEY_LSB = 8;
  localparam int FRAC_LSB = 16;
  localparam int DMA_UPDATE_BIT = 16;
  localparam int VIOL_SRC_LSB = 8;
  localparam logic [31:0] REG_RESET = 32'h0;
  localparam logic [2:0] FRAC_STEPS = 3'h0;
  localparam logic [4:0] OVERSAMPLE_16 = 5'h10;
  localparam logic [4:0] OVERSAMPLE_8 = 5'h08;

  // mode register subset: bit 8 sync, bit 19 over, bit 0 lin master, bit 1 spi
  localparam int MODE_SYNC_BIT = 8;
  localparam int MODE_OVER_BIT = 19;
  localparam int MODE_LIN_MASTER_BIT = 0;
  localparam int MODE_SPI_BIT = 1;

  typedef struct packed {
    logic [7:0] response_length_field;
    logic wakeup_type_bit;
    logic frame_slot_disable;
    logic length_mode_bit;
    logic checksum_type_bit;
    logic checksum_disable;
    logic parity_disable;
    logic [1:0] node_action_field;
  } ublr_lin_cfg_t;

  typedef enum logic [1:0] {
    NODE_RESPOND_TRANSMIT = 2'h0,
    NODE_RESPOND_RECEIVE = 2'h1,
    NODE_IGNORE = 2'h2,
    NODE_RESERVED = 2'h3
  } ublr_node_t;

endpackage

// ---- hdl/ublr_regs.sv ----
`timescale 1ns/1ns
// Operation
// - tx char field holds next queued character
// - fraction zero off, else adds eighths
// - divider zero stops baud clock
// - async rate is clock/16/div or /8/div
// - sync or spi rate is clock/div
// - timeout zero off, else value bit periods
// - guard zero off, else value bit periods
// - protected registers writable only when unprotected
// - enable updates only with key; key reads zero
// - dma writes lin mode except own bit
// - length mode zero gives field plus one
// - length mode one uses identifier bits 5:4
// - wakeup type selects 2.0 or 1.3 wakeup
// - frame slot active while disable bit low
// - checksum type zero enhanced, one classic
// - checksum disable stops generate and check
// - parity disable stops generate and check
// - node action selects transmit, receive, ignore
// - identifier writable as master, received as slave
// - violation sets flag; status read clears all
// - violation source names rejected register offset
module ublr_regs (
  input wire logic core_clk, // module clock
  input wire logic rst, // sync reset, active high
  input wire logic psel, // apb select
  input wire logic penable, // apb enable
  input wire logic pwrite, // apb direction
  input wire logic [7:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error on unmapped address
  input wire logic dma_we, // dma write strobe to lin mode
  input wire logic [31:0] dma_wdata, // dma write data
  input wire logic tx_holding_free_flag, // holding register empty
  input wire logic tx_take, // shifter takes the character
  input wire logic id_rx_valid, // slave received an identifier
  input wire logic [7:0] id_rx_char, // received identifier
  output logic [8:0] tx_char_field, // next character to send
  output logic baud_tick, // one pulse per baud clock
  output logic timeout_en, // receiver timeout active
  output logic [16:0] timeout_value, // timeout in bit periods
  output logic guard_en, // timeguard active
  output logic [7:0] guard_value, // guard in bit periods
  output logic [7:0] response_bytes_m1, // response length minus one
  output ublr_pkg::ublr_lin_cfg_t lin_cfg, // lin config fields
  output logic frame_slot_active, // frame slot mode on
  output logic checksum_gen, // master sends checksum
  output logic checksum_chk, // slave checks checksum
  output logic parity_gen, // master sends parity
  output logic parity_chk, // slave checks parity
  output logic respond_transmit, // node transmits response
  output logic respond_receive, // node receives response
  output logic wakeup_13, // wakeup is 1.3 style
  output logic [7:0] identifier_char // identifier value
);

  // ************************************************************
  // bus decode
  // ************************************************************
  logic [31:0] mode_q, baud_q, rto_q, ttg_q, lin_q, id_q;
  logic [8:0] tx_char_field_q;
  logic protect_enable_q, violation_flag_q;
  logic [15:0] violation_source_q;
  logic [15:0] cnt_q;
  logic [2:0] frac_q;
  logic [4:0] sub_q;

  wire access = psel && penable;
  wire wr = access && pwrite;
  wire rd = access && !pwrite;
  wire hit_mode = paddr == ublr_pkg::MODE_OFF;
  wire hit_thr = paddr == ublr_pkg::TX_HOLD_OFF;
  wire hit_baud = paddr == ublr_pkg::BAUD_DIV_OFF;
  wire hit_rto = paddr == ublr_pkg::RX_TIMEOUT_OFF;
  wire hit_ttg = paddr == ublr_pkg::TX_GUARD_OFF;
  wire hit_lin = paddr == ublr_pkg::LIN_MODE_OFF;
  wire hit_id = paddr == ublr_pkg::LIN_ID_OFF;
  wire hit_wpm = paddr == ublr_pkg::WP_MODE_OFF;
  wire hit_wps = paddr == ublr_pkg::WP_STATUS_OFF;
  wire hit_any = hit_mode | hit_thr | hit_baud | hit_rto | hit_ttg | hit_lin
               | hit_id | hit_wpm | hit_wps;
  wire hit_prot = hit_mode | hit_baud | hit_rto | hit_ttg;
  wire prot_ok = wr && hit_prot && !protect_enable_q;
  wire prot_viol = wr && hit_prot && protect_enable_q;
  wire key_ok = pwdata[31:ublr_pkg::PROTECT_KEY_LSB] == ublr_pkg::PROTECT_KEY_VAL;
  wire lin_master = mode_q[ublr_pkg::MODE_LIN_MASTER_BIT];
  wire sync_mode = mode_q[ublr_pkg::MODE_SYNC_BIT] | mode_q[ublr_pkg::MODE_SPI_BIT];
  wire wps_read = rd && hit_wps;

  assign pready = 1'b1;
  assign pslverr = access && !hit_any;

  always_comb begin
    prdata = 32'h0;
    unique case (1'b1)
      hit_mode: prdata = mode_q;
      hit_baud: prdata = baud_q;
      hit_rto: prdata = rto_q;
      hit_ttg: prdata = ttg_q;
      hit_lin: prdata = lin_q;
      hit_id: prdata = id_q;
      hit_wpm: prdata = {24'h0, 7'h0, protect_enable_q};
      hit_wps: prdata = {8'h0, violation_source_q, 7'h0, violation_flag_q};
      default: prdata = 32'h0;
    endcase
  end

  // ************************************************************
  // register storage
  // ************************************************************
  always_ff @(posedge core_clk) begin
    if (rst) begin
      mode_q <= ublr_pkg::REG_RESET;
      baud_q <= ublr_pkg::REG_RESET;
      rto_q <= ublr_pkg::REG_RESET;
      ttg_q <= ublr_pkg::REG_RESET;
    end else if (prot_ok) begin
      if (hit_mode) mode_q <= pwdata;
      if (hit_baud) baud_q <= {13'h0, pwdata[18:0]};
      if (hit_rto) rto_q <= {15'h0, pwdata[16:0]};
      if (hit_ttg) ttg_q <= {24'h0, pwdata[7:0]};
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      lin_q <= ublr_pkg::REG_RESET;
    end else if (wr && hit_lin) begin
      lin_q <= {15'h0, pwdata[16:0]};
    end else if (dma_we && lin_q[ublr_pkg::DMA_UPDATE_BIT]) begin
      // dma keeps the update bit so it cannot lock itself out
      lin_q <= {15'h0, lin_q[16], dma_wdata[15:0]};
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      id_q <= ublr_pkg::REG_RESET;
    end else if (lin_master && wr && hit_id) begin
      id_q <= {24'h0, pwdata[7:0]};
    end else if (!lin_master && id_rx_valid) begin
      id_q <= {24'h0, id_rx_char};
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      tx_char_field_q <= 9'h0;
    end else if (wr && hit_thr && tx_holding_free_flag) begin
      tx_char_field_q <= pwdata[8:0];
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      protect_enable_q <= 1'b0;
    end else if (wr && hit_wpm && key_ok) begin
      protect_enable_q <= pwdata[0];
    end
  end

  // a new violation in the read cycle wins over the clear
  always_ff @(posedge core_clk) begin
    if (rst) begin
      violation_flag_q <= 1'b0;
      violation_source_q <= 16'h0;
    end else if (prot_viol) begin
      violation_flag_q <= 1'b1;
      violation_source_q <= {8'h0, paddr};
    end else if (wps_read) begin
      violation_flag_q <= 1'b0;
      violation_source_q <= 16'h0;
    end
  end

  // ************************************************************
  // baud generator
  // ************************************************************
  wire [15:0] clock_divider_value = baud_q[15:0];
  wire [2:0] frac_divider = baud_q[ublr_pkg::FRAC_LSB +: 3];
  wire [4:0] over_n = mode_q[ublr_pkg::MODE_OVER_BIT] ? ublr_pkg::OVERSAMPLE_8
                                                      : ublr_pkg::OVERSAMPLE_16;
  // fraction stretches one divider period per eighth of the cycle
  wire frac_stretch = (frac_divider != ublr_pkg::FRAC_STEPS) && (frac_q < frac_divider);
  wire [15:0] cnt_end = frac_stretch ? clock_divider_value : clock_divider_value - 16'h1;
  wire cnt_wrap = cnt_q >= cnt_end;
  wire sub_last = sync_mode || (sub_q == over_n - 5'h1);

  always_ff @(posedge core_clk) begin
    if (rst || clock_divider_value == 16'h0) begin
      cnt_q <= 16'h0;
      sub_q <= 5'h0;
      frac_q <= 3'h0;
      baud_tick <= 1'b0;
    end else begin
      baud_tick <= 1'b0;
      if (cnt_wrap) begin
        cnt_q <= 16'h0;
        sub_q <= sub_last ? 5'h0 : sub_q + 5'h1;
        frac_q <= frac_q + 3'h1;
        baud_tick <= sub_last;
      end else begin
        cnt_q <= cnt_q + 16'h1;
      end
    end
  end

  // ************************************************************
  // decoded configuration
  // ************************************************************
  assign tx_char_field = tx_char_field_q;
  assign timeout_value = rto_q[16:0];
  assign timeout_en = rto_q[16:0] != 17'h0;
  assign guard_value = ttg_q[7:0];
  assign guard_en = ttg_q[7:0] != 8'h0;
  assign lin_cfg = ublr_pkg::ublr_lin_cfg_t'(lin_q[15:0]);
  assign identifier_char = id_q[7:0];
  assign response_bytes_m1 = lin_cfg.length_mode_bit ? {6'h0, id_q[5:4]}
                                                     : lin_cfg.response_length_field;
  assign wakeup_13 = lin_cfg.wakeup_type_bit;
  assign frame_slot_active = !lin_cfg.frame_slot_disable;
  assign checksum_gen = !lin_cfg.checksum_disable && lin_master;
  assign checksum_chk = !lin_cfg.checksum_disable && !lin_master;
  assign parity_gen = !lin_cfg.parity_disable && lin_master;
  assign parity_chk = !lin_cfg.parity_disable && !lin_master;
  assign respond_transmit = lin_cfg.node_action_field == ublr_pkg::NODE_RESPOND_TRANSMIT;
  assign respond_receive = lin_cfg.node_action_field == ublr_pkg::NODE_RESPOND_RECEIVE;
  // checksum_type_bit travels in lin_cfg: 0 enhanced, 1 classic

endmodule

// ---- dv/ublr_regs_asserts.sv ----
`timescale 1ns/1ns
module ublr_regs_asserts (
  input wire logic core_clk, // clock
  input wire logic rst, // reset
  input wire logic psel, // apb select
  input wire logic penable, // apb enable
  input wire logic pwrite, // apb write
  input wire logic [7:0] paddr, // apb address
  input wire logic [31:0] pwdata, // apb wdata
  input wire logic [31:0] prdata, // apb rdata
  input wire logic dma_we, // dma strobe
  input wire logic timeout_en, // timeout on
  input wire logic [16:0] timeout_value, // timeout
  input wire logic guard_en, // guard on
  input wire logic [7:0] guard_value, // guard
  input wire logic [7:0] response_bytes_m1, // length
  input ublr_pkg::ublr_lin_cfg_t lin_cfg, // lin fields
  input wire logic frame_slot_active, // slot mode
  input wire logic respond_transmit, // transmit role
  input wire logic respond_receive, // receive role
  input wire logic wakeup_13 // wakeup style
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  // ************************************************************
  // checks
  // ************************************************************
  key_reads_zero_a: assert property (psel && penable && !pwrite && paddr == 8'he4
    |-> prdata[31:8] == 24'h0) else $error("key field not zero on read");
  timeout_enable_a: assert property (timeout_en == (timeout_value != 17'h0))
    else $error("timeout enable wrong");
  guard_enable_a: assert property (guard_en == (guard_value != 8'h0))
    else $error("guard enable wrong");
  length_field_a: assert property (!lin_cfg.length_mode_bit
    |-> response_bytes_m1 == lin_cfg.response_length_field) else $error("length wrong");
  frame_slot_a: assert property (frame_slot_active == !lin_cfg.frame_slot_disable)
    else $error("frame slot wrong");
  node_role_a: assert property (respond_transmit == (lin_cfg.node_action_field == 2'h0)
    && respond_receive == (lin_cfg.node_action_field == 2'h1)) else $error("role wrong");
  wakeup_style_a: assert property (wakeup_13 == lin_cfg.wakeup_type_bit)
    else $error("wakeup style wrong");
  lin_write_a: assert property (psel && penable && pwrite && paddr == 8'h54 && !dma_we
    |=> lin_cfg == $past(pwdata[15:0])) else $error("lin write lost");
endmodule
bind ublr_regs ublr_regs_asserts u_chk (.*);

// ---- dv/ublr_line_model.sv ----
`timescale 1ns/1ns
module ublr_line_model (
  input wire logic core_clk, // clock
  output logic tx_holding_free_flag, // holding empty
  output logic tx_take, // shifter take
  output logic id_rx_valid, // id strobe
  output logic [7:0] id_rx_char // received id
);
  // ************************************************************
  // far side of the line
  // ************************************************************
  initial begin
    tx_holding_free_flag = 1'b1;
    tx_take = 1'b0;
    id_rx_valid = 1'b0;
    id_rx_char = 8'h0;
  end
  task automatic set_free(input logic f);
    @(posedge core_clk);
    tx_holding_free_flag <= f;
  endtask
  task automatic send_id(input logic [7:0] c);
    @(posedge core_clk);
    id_rx_valid <= 1'b1;
    id_rx_char <= c;
    @(posedge core_clk);
    id_rx_valid <= 1'b0;
    // stale char must not look valid after the strobe
    id_rx_char <= ~c;
  endtask
endmodule

// ---- dv/usart_baud_lin_wprot_regs_bench.sv ----
`timescale 1ns/1ns
module usart_baud_lin_wprot_regs_bench;
  logic core_clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic dma_we = 1'b0, pready, pslverr, er, tx_holding_free_flag, tx_take, id_rx_valid;
  logic [7:0] paddr = 8'h0, id_rx_char, guard_value, response_bytes_m1, identifier_char;
  logic [31:0] pwdata = 32'h0, dma_wdata = 32'h0, prdata, rd;
  logic baud_tick, timeout_en, guard_en, frame_slot_active, checksum_gen, checksum_chk;
  logic parity_gen, parity_chk, respond_transmit, respond_receive, wakeup_13;
  logic [8:0] tx_char_field;
  logic [16:0] timeout_value;
  ublr_pkg::ublr_lin_cfg_t lin_cfg;
  int num_errors = 0, checks_done = 0;
  ublr_regs u_dut (.*);
  ublr_line_model u_line (.*);
  // ************************************************************
  // helpers
  // ************************************************************
  initial forever #10 core_clk = ~core_clk;
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      num_errors++;
      $display("[ERR] %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do @(posedge core_clk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk($sformatf("reg_%h", a), e, rd);
  endtask
  task automatic per(input int e, input int k = 1);
    int n;
    n = 0;
    // skip the first two ticks, they may belong to the old setting
    repeat (2) do @(posedge core_clk); while (baud_tick !== 1'b1);
    // k periods together, so a fraction shows as whole extra cycles
    repeat (k) begin
      do begin
        @(posedge core_clk);
        n++;
      end while (baud_tick !== 1'b1);
    end
    chk("baud_period", e, n);
  endtask
  task automatic summarize;
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // ************************************************************
  // scenarios
  // ************************************************************
  task automatic t_reset;
    logic [7:0] offs [7] = '{8'h20, 8'h24, 8'h28, 8'h54, 8'h58, 8'he4, 8'he8};
    foreach (offs[i]) rc(offs[i], 32'h0);
    apb(1'b0, 8'hf0, 32'h0);
    chk("unmapped_err", 32'h1, {31'h0, er});
  endtask
  task automatic t_prot;
    logic [7:0] po [3] = '{8'h20, 8'h24, 8'h28};
    apb(1'b1, 8'he4, 32'h12345601);
    rc(8'he4, 32'h0);
    apb(1'b1, 8'he4, {ublr_pkg::PROTECT_KEY_VAL, 8'h01});
    rc(8'he4, 32'h1);
    foreach (po[i]) begin
      apb(1'b1, po[i], 32'h5);
      rc(po[i], 32'h0);
      rc(8'he8, {16'h0, po[i], 8'h01});
    end
    rc(8'he8, 32'h0);
    apb(1'b1, 8'he4, {ublr_pkg::PROTECT_KEY_VAL, 8'h00});
    apb(1'b1, 8'h20, 32'h3);
    rc(8'h20, 32'h3);
  endtask
  task automatic t_baud;
    apb(1'b1, 8'h20, 32'h2);
    apb(1'b1, 8'h04, 32'h0);
    per(32);
    apb(1'b1, 8'h04, 32'h00080000);
    per(16);
    apb(1'b1, 8'h04, 32'h00000100);
    per(2);
    apb(1'b1, 8'h04, 32'h00000002);
    per(2);
    apb(1'b1, 8'h20, 32'h00020002);
    per(18, 8);
    apb(1'b1, 8'h20, 32'h0);
    repeat (100) @(posedge core_clk);
    chk("baud_stopped", 32'h0, {31'h0, baud_tick});
  endtask
  task automatic t_lin;
    logic [31:0] v [5] = '{32'h0500, 32'hff81, 32'h0046, 32'h345e, 32'hab9f};
    foreach (v[i]) begin
      apb(1'b1, 8'h54, v[i]);
      @(negedge core_clk);
      chk("lin_cfg", v[i], {16'h0, lin_cfg});
      chk("len", {24'h0, v[i][15:8]}, {24'h0, response_bytes_m1});
      chk("disables", 32'h0, {30'h0, v[i][3] & (checksum_gen | checksum_chk),
        v[i][2] & (parity_gen | parity_chk)});
    end
    apb(1'b1, 8'h54, 32'h1);
    dma_we <= 1'b1;
    dma_wdata <= 32'h2;
    @(posedge core_clk);
    dma_we <= 1'b0;
    rc(8'h54, 32'h1);
    apb(1'b1, 8'h54, 32'h00010001);
    dma_we <= 1'b1;
    @(posedge core_clk);
    dma_we <= 1'b0;
    rc(8'h54, 32'h00010002);
  endtask
  task automatic t_id;
    apb(1'b1, 8'h04, 32'h1);
    apb(1'b1, 8'h58, 32'h3c);
    rc(8'h58, 32'h3c);
    apb(1'b1, 8'h54, 32'h20);
    @(negedge core_clk);
    chk("len_from_id", 32'h3, {24'h0, response_bytes_m1});
    apb(1'b1, 8'h04, 32'h0);
    u_line.send_id(8'h2a);
    apb(1'b1, 8'h58, 32'h11);
    rc(8'h58, 32'h2a);
    apb(1'b1, 8'h1c, 32'h1a5);
    u_line.set_free(1'b0);
    apb(1'b1, 8'h1c, 32'h055);
    @(negedge core_clk);
    chk("tx_char", 32'h1a5, {23'h0, tx_char_field});
  endtask
  initial begin
    #400000;
    num_errors++;
    summarize();
  end
  initial begin
    repeat (5) @(posedge core_clk);
    rst <= 1'b0;
    t_reset();
    t_prot();
    t_baud();
    t_lin();
    t_id();
    summarize();
  end
endmodule
